/* hdl/edzs_ctrl.sv */
// Notes on behaviour
// - Direction input low counts clockwise up; high counts clockwise down.
// - A fixed build option inverts the default counting sense.
// - Direction change after power-up is an error; fault output goes low.
// - Direction changes are acted upon well within 1 ms.
// - Position is marked invalid for 150 ms after power-on.
// - Zero-preset input makes the current shaft position the new zero.
// - Fault output high normally, low while any alarm is active.
// - Fault indication stays latched until power is removed; the code also clears it when i_resetn goes low.
// - Zeroed position becomes readable 1 ms after zero-preset assertion.
module edzs_ctrl
    import edzs_pkg::*;
#(
    parameter logic INVERT_DEFAULT = 1'b0,
    parameter logic [CNT_W-1:0] POWER_ON_CYCLES = CNT_W'(POWER_ON_CYC)
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    // pins from the controller
    input  wire logic i_dir_pin,
    input  wire logic i_zero_pin,
    // sensing front end
    input  wire logic i_step,
    input  wire logic i_clockwise_sense,
    input  wire edzs_pkg::edzs_alarm_type i_alarm,
    // outputs
    output edzs_pkg::edzs_pos_type o_pos,
    output logic o_fault_n,
    output logic o_count_down
);
    import edzs_pkg::*;

    logic dir_s1_reg, dir_s2_reg, zero_s1_reg, zero_s2_reg, zero_d_reg;
    logic dir_cap_reg, dir_cap_next;
    logic [CNT_W-1:0] pon_reg, pon_next;
    edzs_state_type state_reg, state_next;
    logic [POS_W-1:0] raw_reg, raw_next;
    logic [POS_W-1:0] offs_reg, offs_next;
    edzs_pos_type pos_reg, pos_next;
    logic fault_n_reg, fault_n_next;
    logic down_reg, down_next;
    logic latch_reg, latch_next;
    logic zero_rise, zero_busy, zero_done;

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dir_s1_reg <= 1'b0;
            dir_s2_reg <= 1'b0;
            zero_s1_reg <= 1'b0;
            zero_s2_reg <= 1'b0;
            zero_d_reg <= 1'b0;
        end else if (i_ce) begin
            dir_s1_reg <= i_dir_pin;
            dir_s2_reg <= dir_s1_reg;
            zero_s1_reg <= i_zero_pin;
            zero_s2_reg <= zero_s1_reg;
            zero_d_reg <= zero_s2_reg;
        end
    end

    assign zero_rise = zero_s2_reg & ~zero_d_reg;

    edzs_delay #(
        .LOAD(DLY_W'(ZERO_READY_CYC))
    ) u_zero_delay (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_start(zero_rise),
        .o_busy(zero_busy),
        .o_done(zero_done)
    );

    always_comb begin
        state_next = state_reg;
        pon_next = pon_reg;
        dir_cap_next = dir_cap_reg;
        latch_next = latch_reg;
        case (state_reg)
            EDZS_ST_POWERUP: begin
                if (pon_reg >= POWER_ON_CYCLES - 25'h000_0001) begin
                    dir_cap_next = dir_s2_reg;
                    state_next = EDZS_ST_RUN;
                end else begin
                    pon_next = pon_reg + 25'h000_0001;
                end
            end
            EDZS_ST_RUN: begin
                if (dir_s2_reg != dir_cap_reg) begin
                    latch_next = 1'b1;
                    state_next = EDZS_ST_FAULT;
                end
            end
            EDZS_ST_FAULT: begin
                latch_next = 1'b1;
            end
            default: begin
                state_next = EDZS_ST_POWERUP;
            end
        endcase
        if (i_alarm.sensor_err || i_alarm.light_err || i_alarm.temp_err) begin
            latch_next = 1'b1;
        end
    end

    always_comb begin
        // counting sense, follows the live input within cycles
        down_next = dir_s2_reg ^ INVERT_DEFAULT;
        raw_next = raw_reg;
        // step direction uses the registered sense down_reg, one cycle behind the synchronised level
        if (i_step) begin
            if (i_clockwise_sense ^ down_reg) begin
                raw_next = raw_reg + 41'h000_0000_0001;
            end else begin
                raw_next = raw_reg - 41'h000_0000_0001;
            end
        end
        offs_next = zero_rise ? raw_reg : offs_reg;
        pos_next.value = raw_reg - offs_reg;
        // valid only after hold-off and zero settle
        pos_next.valid = (state_reg != EDZS_ST_POWERUP) && !zero_busy && !zero_rise;
        if (zero_done) begin
            pos_next.valid = (state_reg != EDZS_ST_POWERUP);
        end
        // fault output low while alarm or latched error
        fault_n_next = ~latch_next;
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg <= EDZS_ST_POWERUP;
            pon_reg <= CNT_RST;
            dir_cap_reg <= 1'b0;
            latch_reg <= 1'b0;
            down_reg <= INVERT_DEFAULT;
            raw_reg <= POS_RST;
            offs_reg <= POS_RST;
            pos_reg <= '0;
            fault_n_reg <= 1'b1;
        end else if (i_ce) begin
            state_reg <= state_next;
            pon_reg <= pon_next;
            dir_cap_reg <= dir_cap_next;
            latch_reg <= latch_next;
            down_reg <= down_next;
            raw_reg <= raw_next;
            offs_reg <= offs_next;
            pos_reg <= pos_next;
            fault_n_reg <= fault_n_next;
        end
    end

    assign o_pos = pos_reg;
    assign o_fault_n = fault_n_reg;
    assign o_count_down = down_reg;
endmodule

/* hdl/edzs_pkg.sv */
package edzs_pkg;

    // clock rate
    localparam int unsigned CLK_HZ = 100_000_000;

    // documented times in their own units
    localparam int unsigned POWER_ON_MS = 150;
    localparam int unsigned DIR_RESP_MS = 1;
    localparam int unsigned ZERO_READY_MS = 1;

    // derived cycle counts (longest times round down)
    localparam int unsigned POWER_ON_CYC = POWER_ON_MS * (CLK_HZ / 1000);
    localparam int unsigned DIR_RESP_CYC = DIR_RESP_MS * (CLK_HZ / 1000);
    localparam int unsigned ZERO_READY_CYC = ZERO_READY_MS * (CLK_HZ / 1000);

    localparam int POS_W = 41;
    localparam int CNT_W = 25;
    localparam int DLY_W = 18;

    // reset values
    localparam logic [POS_W-1:0] POS_RST = 41'h000_0000_0000;
    localparam logic [CNT_W-1:0] CNT_RST = 25'h000_0000;
    localparam logic [DLY_W-1:0] DLY_RST = 18'h0_0000;

    typedef enum logic [1:0] {
        EDZS_ST_POWERUP = 2'b00,
        EDZS_ST_RUN     = 2'b01,
        EDZS_ST_FAULT   = 2'b10
    } edzs_state_type;

    // alarm inputs from the sensing front end
    typedef struct packed {
        logic sensor_err;
        logic light_err;
        logic temp_err;
    } edzs_alarm_type;

    // reported position with its qualifier
    typedef struct packed {
        logic valid;
        logic [POS_W-1:0] value;
    } edzs_pos_type;

endpackage

/* hdl/edzs_delay.sv */
// one-shot countdown: o_busy rises on start and o_done pulses after the load count
module edzs_delay
    import edzs_pkg::*;
#(
    parameter logic [DLY_W-1:0] LOAD = 18'h0_0001
) (
    // clock and reset
    input  wire logic i_ref_clk,
    input  wire logic i_resetn,
    input  wire logic i_ce,
    // control
    input  wire logic i_start,
    output logic o_busy,
    output logic o_done
);
    import edzs_pkg::*;

    logic [DLY_W-1:0] cnt_reg, cnt_next;
    logic busy_reg, busy_next;
    logic done_reg, done_next;

    always_comb begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        done_next = 1'b0;
        if (i_start) begin
            cnt_next = LOAD;
            busy_next = 1'b1;
        end else if (busy_reg) begin
            if (cnt_reg <= 18'h0_0001) begin
                busy_next = 1'b0;
                done_next = 1'b1;
                cnt_next = DLY_RST;
            end else begin
                cnt_next = cnt_reg - 18'h0_0001;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_reg <= DLY_RST;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (i_ce) begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
            done_reg <= done_next;
        end
    end

    assign o_busy = busy_reg;
    assign o_done = done_reg;
endmodule

/* tb/edzs_ctrl_asserts.sv */
module edzs_ctrl_asserts
    import edzs_pkg::*;
#(
    parameter logic INVERT_DEFAULT = 1'b0,
    parameter logic [CNT_W-1:0] POWER_ON_CYCLES = 25'h000_0032
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // watched signals
    input wire logic i_dir_pin,
    input wire logic i_zero_pin,
    input wire logic i_step,
    input wire logic i_clockwise_sense,
    input wire edzs_pkg::edzs_alarm_type i_alarm,
    input wire edzs_pkg::edzs_pos_type o_pos,
    input wire logic o_fault_n,
    input wire logic o_count_down
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn)
            cyc <= 0;
        else if (cyc < 32'h7FFF_FFFE)
            cyc <= cyc + 1;
    end
    a_dir_sense: assert property ($past(i_resetn, 3) |->
        o_count_down == ($past(i_dir_pin, 3) ^ INVERT_DEFAULT)) else $error("sense wrong");
    a_dir_fault: assert property ($changed(i_dir_pin) && cyc > POWER_ON_CYCLES + 8
        |-> ##[1:5] !o_fault_n) else $error("dir change no fault");
    a_fault_latch: assert property (!o_fault_n |=> !o_fault_n) else $error("fault cleared");
    a_alarm_fault: assert property (|i_alarm |=> !o_fault_n) else $error("alarm no fault");
    a_fault_cause: assert property ($fell(o_fault_n) |->
        $past(|i_alarm) || cyc > POWER_ON_CYCLES) else $error("fault without cause");
    a_valid_holdoff: assert property (cyc + 2 < POWER_ON_CYCLES |-> !o_pos.valid)
        else $error("valid too early");
    a_valid_rise: assert property (cyc == POWER_ON_CYCLES + 6 |-> o_pos.valid)
        else $error("valid late");
    a_zero_drop: assert property ($rose(i_zero_pin) && o_pos.valid
        |-> ##[2:6] !o_pos.valid) else $error("zero not taken");
    a_ce_freeze: assert property (!i_ce |=> $stable(o_pos) && $stable(o_fault_n)
        && $stable(o_count_down)) else $error("state moved while disabled");
endmodule

bind edzs_ctrl edzs_ctrl_asserts #(.INVERT_DEFAULT(INVERT_DEFAULT),
    .POWER_ON_CYCLES(POWER_ON_CYCLES)) u_edzs_ctrl_asserts (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_dir_pin(i_dir_pin),
    .i_zero_pin(i_zero_pin), .i_step(i_step), .i_clockwise_sense(i_clockwise_sense),
    .i_alarm(i_alarm), .o_pos(o_pos), .o_fault_n(o_fault_n), .o_count_down(o_count_down)
);

/* tb/edzs_host_model.sv */
module edzs_host_model (
    // clock
    input wire logic i_ref_clk,
    // pins to the encoder
    output logic o_dir_pin,
    output logic o_zero_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_dir_pin = 1'b0;
        o_zero_pin = 1'b0;
    end
    task automatic set_dir(input logic v);
        @(posedge i_ref_clk);
        #1 o_dir_pin = v;
    endtask
    // zero request held well past sync
    task automatic pulse_zero();
        @(posedge i_ref_clk);
        #1 o_zero_pin = 1'b1;
        repeat (20) @(posedge i_ref_clk);
        #1 o_zero_pin = 1'b0;
    endtask
endmodule

/* tb/edzs_ctrl_tb_top.sv */
module edzs_ctrl_tb_top
    import edzs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [CNT_W-1:0] PON = 25'h000_0032;
    logic clk, rst_n, ce, step, cw, dir, zero, fault_n, cdown;
    edzs_alarm_type alarm;
    edzs_pos_type pos;
    int errors = 0;
    int n_tests = 0;
    int cyc = 0;
    int k;
    edzs_ctrl #(.INVERT_DEFAULT(1'b1), .POWER_ON_CYCLES(PON)) u_edzs_ctrl (
        .i_ref_clk(clk), .i_resetn(rst_n), .i_ce(ce), .i_dir_pin(dir),
        .i_zero_pin(zero), .i_step(step), .i_clockwise_sense(cw), .i_alarm(alarm),
        .o_pos(pos), .o_fault_n(fault_n), .o_count_down(cdown));
    edzs_host_model u_edzs_host_model (.i_ref_clk(clk), .o_dir_pin(dir), .o_zero_pin(zero));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 120000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
        end
    endtask
    task automatic do_step(input logic sense);
        step = 1'b1;
        cw = sense;
        tick(1);
        step = 1'b0;
        tick(2);
    endtask
    task automatic do_reset();
        rst_n = 1'b0;
        tick(6);
        rst_n = 1'b1;
    endtask
    initial begin
        {step, cw, alarm} = '0;
        ce = 1'b1;
        do_reset();
        u_edzs_host_model.set_dir(1'b1);
        tick(9);
        chk(pos.valid, 1'b0);
        tick(PON + 6);
        chk(fault_n, 1'b1);
        chk(pos.valid, 1'b1);
        chk(cdown, 1'b0);
        for (int i = 0; i < 3; i++)
            do_step(1'b1);
        do_step(1'b0);
        chk(pos.value, 41'h002);
        u_edzs_host_model.pulse_zero();
        k = 0;
        while (pos.valid !== 1'b1 && k < 110000) begin
            tick(1);
            k++;
        end
        chk(k + 21 >= ZERO_READY_CYC, 1'b1);
        chk(k + 21 <= ZERO_READY_CYC + 10, 1'b1);
        chk(pos.value, 41'h000);
        do_step(1'b0);
        chk(pos.value, {POS_W{1'b1}});
        u_edzs_host_model.set_dir(1'b0);
        tick(6);
        chk(fault_n, 1'b0);
        chk(cdown, 1'b1);
        do_step(1'b1);
        chk(pos.value, {{(POS_W - 1){1'b1}}, 1'b0});
        tick(20);
        chk(fault_n, 1'b0);
        // a step while the clock enable is low must not move anything
        ce = 1'b0;
        do_step(1'b1);
        ce = 1'b1;
        tick(2);
        chk(pos.value, {{(POS_W - 1){1'b1}}, 1'b0});
        chk(fault_n, 1'b0);
        for (int i = 0; i < 3; i++) begin
            do_reset();
            tick(PON + 6);
            chk(fault_n, 1'b1);
            alarm = edzs_alarm_type'(3'h1 << i);
            tick(1);
            alarm = '0;
            tick(3);
            chk(fault_n, 1'b0);
        end
        print_verdict();
    end
endmodule
